// [gpt_pin_model.sv]
/*
  gpt_pin_model: the outside world at the five count and gate pins,
  one pin per timer, each level changed just after a clock edge.
  assumes: the timer block samples the pins on pclk.
*/
`timescale 1ns/1ns
module gpt_pin_model (
  input wire logic pclk,
  output logic [gpt_pkg::NUM_TMR-1:0] ext_count_pin
);
  import gpt_pkg::*;
  // ============================================================
  // pin drive
  // pins rest low so reset release never shows a false rising edge
  initial ext_count_pin = '0;
  // two cycles high, two low: slow enough for the two-stage syncing
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      ext_count_pin[idx] <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_count_pin[idx] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : pulse
  // gate level, held until the next call
  task automatic level(input int idx, input logic v);
    ext_count_pin[idx] <= v;
    @(posedge pclk);
  endtask : level
endmodule : gpt_pin_model

// [gpt_pkg.sv]
/*
  gpt_pkg: constants, register map, field layout and helper functions
  for the general purpose timer block.
  assumes: shared by the timer top, its prescaler and their interface.
*/
package gpt_pkg;

  // ==========================================================
  // bus widths and timer numbering
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PS_W = 2;
  localparam int NUM_TMR = 5;
  localparam int T_SOLO = 0;
  localparam int T_A_EVEN = 1;
  localparam int T_A_ODD = 2;
  localparam int T_B_EVEN = 3;
  localparam int T_B_ODD = 4;

  // ==========================================================
  // register map: three words per timer, then the flag word
  localparam logic [7:0] OFS_STRIDE = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h3C;

  // ==========================================================
  // control word fields
  localparam int RUN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PS_HI = 5;
  localparam int PS_LO = 4;
  localparam int WIDE_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int SRC_BIT = 1;
  localparam logic [15:0] MASK_SOLO = 16'hA076;
  localparam logic [15:0] MASK_EVEN = 16'hA07A;
  localparam logic [15:0] MASK_ODD = 16'hA072;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;

  // ==========================================================
  // prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_TERM_1 = 8'h00;
  localparam logic [7:0] PS_TERM_8 = 8'h07;
  localparam logic [7:0] PS_TERM_64 = 8'h3F;
  localparam logic [7:0] PS_TERM_256 = 8'hFF;

  typedef enum {GPT_TIMER, GPT_GATED, GPT_SYNC_CNT, GPT_ASYNC_CNT}
    gpt_mode_type;

  // ==========================================================
  // helpers
  function automatic logic [7:0] gpt_ps_term(input logic [PS_W-1:0] sel);
    case (sel)
      2'h3: return PS_TERM_256;
      2'h2: return PS_TERM_64;
      2'h1: return PS_TERM_8;
      default: return PS_TERM_1;
    endcase
  endfunction : gpt_ps_term

  function automatic gpt_mode_type gpt_mode(input logic [15:0] c);
    if (!c[SRC_BIT])
      return c[GATE_BIT] ? GPT_GATED : GPT_TIMER;
    return c[SYNC_BIT] ? GPT_SYNC_CNT : GPT_ASYNC_CNT;
  endfunction : gpt_mode

  function automatic logic [7:0] gpt_reg_addr(input int idx,
                                              input logic [7:0] fld);
    return 8'(idx * 12) + fld;
  endfunction : gpt_reg_addr

endpackage : gpt_pkg

// [gpt_prescaler.sv]
/*
  gpt_prescaler: input clock divider of one timer, with optional
  two-stage synchronisation of its output.
  assumes: tick_in is a count enable on pclk, one tick per high cycle.
*/
`timescale 1ns/1ns
module gpt_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  gpt_tick_if.core tk
);
  import gpt_pkg::*;

  typedef struct packed {
    logic [7:0] div;
    logic fire;
    logic [1:0] sync;
  } gpt_pre_type;

  gpt_pre_type r_reg;
  gpt_pre_type r_next;

  // ==========================================================
  // divider: the count restarts whenever the timer is stopped
  always_comb
  begin
    r_next = r_reg;
    r_next.fire = 1'b0;
    if (!tk.run)
      r_next.div = 8'h00;
    else if (tk.tick_in)
    begin
      if (r_reg.div >= gpt_ps_term(tk.prescale_sel))
      begin
        r_next.div = 8'h00;
        r_next.fire = 1'b1;
      end
      else
        r_next.div = r_reg.div + 8'h01;
    end
    // sync stage sits behind the divider, not in front of it
    r_next.sync = {r_reg.sync[0], r_reg.fire};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // unsynced path costs no latency; synced adds two cycles
  assign tk.ptick = tk.sync_en ? r_reg.sync[1] : r_reg.fire;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_div_one;
    (tk.run && tk.tick_in && tk.prescale_sel == 2'h0) |=> r_reg.fire;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("1:1 prescale did not pass the tick");

  property p_div_spacing;
    (r_reg.fire && tk.prescale_sel != 2'h0) |=> !r_reg.fire;
  endproperty
  a_div_spacing: assert property (p_div_spacing)
    else $error("divided strobe fired twice in a row");

  property p_sync_delay;
    r_reg.fire |-> ##2 (!tk.sync_en || tk.ptick);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synced strobe not two cycles behind divider");

endmodule : gpt_prescaler

// [gpt_tick_if.sv]
/*
  gpt_tick_if: count enable from a timer's control logic to its
  prescaler, and the prescaled count strobe back.
  assumes: one pclk domain on both sides.
*/
`timescale 1ns/1ns
interface gpt_tick_if;
  logic run;
  logic sync_en;
  logic tick_in;
  logic [gpt_pkg::PS_W-1:0] prescale_sel;
  logic ptick;
  modport core (input run, input sync_en, input tick_in,
                input prescale_sel, output ptick);
  modport ctrl (output run, output sync_en, output tick_in,
                output prescale_sel, input ptick);
endinterface : gpt_tick_if

// [gpt_timers.sv]
/*
  gpt_timers: one standalone 16-bit timer and two timer pairs that
  run as 16-bit timers or join into 32-bit timers, behind APB.
  assumes: APB master on pclk; count pins and the idle and sleep
  levels are synchronous to pclk.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// ============================================================
// Function
// - standalone timer is a 16-bit free running timer or event counter
// - mode comes from source, gate and sync control bits
// - timer modes use internal clock; counter modes use the count pin
// - external source counts on rising edges of the count pin
// - external input may be unsynced; syncing follows the prescaler
// - run bit 15 starts the standalone timer, clearing it stops it
// - idle-stop bit 13 halts the timer during idle when set
// - gate bit 6 enables gated accumulation, ignored on external source
// - prescale bits 5-4 divide by 1, 8, 64 or 256
// - sync bit 2 syncs the external input, ignored on internal source
// - source bit 1 picks count pin when set, internal clock when clear
// - standalone count writes ignored while running as synchronous counter
// - unimplemented standalone control bits read as zero
// - pairs run as two 16-bit timers, 32-bit timer or counter
// - even timer is the low word, odd timer the high word
// - 32-bit pair obeys even control, clock and gate; odd ignored
// - 32-bit pair raises its event on the odd timer's flag
// - 32-bit pair flags when count matches its 32-bit period
// - only the first pair triggers the converter
// - only the four paired timers request DMA transfers
// - only the first pair supplies capture and compare time bases
// - paired timers keep running in idle per idle-stop; in sleep only on the count pin
// - even control bit 3 joins the pair into one 32-bit timer
module gpt_timers (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [gpt_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpt_pkg::DATA_W-1:0] pwdata,
  output logic [gpt_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpt_pkg::NUM_TMR-1:0] ext_count_pin,
  input wire logic device_idle,
  input wire logic device_sleep,
  output logic [gpt_pkg::NUM_TMR-1:0] irq_flag,
  output logic adc1_trigger,
  output logic [3:0] dma_req,
  output logic [15:0] time_base_a_even,
  output logic [15:0] time_base_a_odd
);
  import gpt_pkg::*;

  typedef struct packed {
    logic [NUM_TMR-1:0][15:0] ctrl;
    logic [NUM_TMR-1:0][15:0] cnt;
    logic [NUM_TMR-1:0][15:0] per;
    logic [NUM_TMR-1:0] flag;
    logic [NUM_TMR-1:0] pin_prev;
    logic [3:0] dma;
    logic adc;
    logic [1:0][15:0] base;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } gpt_state_type;

  gpt_state_type s_reg;
  gpt_state_type s_next;

  gpt_tick_if tif [NUM_TMR] ();

  logic wide_a;
  logic wide_b;
  logic [NUM_TMR-1:0] in_wide;
  logic [NUM_TMR-1:0][15:0] eff;
  logic [NUM_TMR-1:0] pin_now;
  logic [NUM_TMR-1:0] pin_old;
  logic [NUM_TMR-1:0] run_ok;
  logic [NUM_TMR-1:0] gated;
  logic [NUM_TMR-1:0] rise;
  logic [NUM_TMR-1:0] fall;
  logic [NUM_TMR-1:0] ptick;
  logic [NUM_TMR-1:0] ev;
  logic [NUM_TMR-1:0] cnt_wr;
  logic [NUM_TMR-1:0] hit_ctrl;
  logic [NUM_TMR-1:0] hit_cnt;
  logic [NUM_TMR-1:0] hit_per;
  logic hit_flags;
  logic acc;
  logic wr;
  logic solo_sync_run;

  // count step shared by 16- and 32-bit paths: {match, next count}
  function automatic logic [32:0] gpt_step(input logic [31:0] c,
                                           input logic [31:0] p);
    if (c == p)
      return {1'b1, 32'h0000_0000};
    return {1'b0, c + 32'h0000_0001};
  endfunction : gpt_step

  // ==========================================================
  // effective control per timer: a joined odd timer follows its even
  always_comb
  begin
    wide_a = s_reg.ctrl[T_A_EVEN][WIDE_BIT];
    wide_b = s_reg.ctrl[T_B_EVEN][WIDE_BIT];
    in_wide = {wide_b, wide_b, wide_a, wide_a, 1'b0};
    for (int i = 0; i < NUM_TMR; i++)
    begin
      eff[i] = s_reg.ctrl[i];
      pin_now[i] = ext_count_pin[i];
      pin_old[i] = s_reg.pin_prev[i];
      // odd control, clock and gate pin ignored when joined
      if (in_wide[i] && (i == T_A_ODD || i == T_B_ODD))
      begin
        eff[i] = s_reg.ctrl[i - 1];
        pin_now[i] = ext_count_pin[i - 1];
        pin_old[i] = s_reg.pin_prev[i - 1];
      end
      // idle halts only when idle-stop is set (even bit for a pair)
      run_ok[i] = eff[i][RUN_BIT] && !(device_idle && eff[i][IDLE_BIT]);
      gated[i] = !eff[i][SRC_BIT] && eff[i][GATE_BIT];
      rise[i] = pin_now[i] && !pin_old[i];
      fall[i] = !pin_now[i] && pin_old[i];
    end
    solo_sync_run = gpt_mode(s_reg.ctrl[T_SOLO]) == GPT_SYNC_CNT
                    && s_reg.ctrl[T_SOLO][RUN_BIT];
  end

  // ==========================================================
  // count sources and prescalers, one per timer
  for (genvar g = 0; g < NUM_TMR; g++)
  begin : g_tmr
    // a joined odd prescaler stays cleared so no stray tick leaks out
    assign tif[g].run = eff[g][RUN_BIT]
      && !(in_wide[g] && (g == T_A_ODD || g == T_B_ODD));
    assign tif[g].prescale_sel = eff[g][PS_HI:PS_LO];
    // pairs only count synchronously; the standalone may run unsynced
    assign tif[g].sync_en = eff[g][SRC_BIT]
      && (g != T_SOLO || eff[g][SYNC_BIT]);
    // pin edges when external, else internal clock (stops in sleep)
    assign tif[g].tick_in = run_ok[g] && (eff[g][SRC_BIT] ? rise[g]
      : (!device_sleep && (!eff[g][GATE_BIT] || pin_now[g])));
    assign ptick[g] = tif[g].ptick;
    gpt_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .tk(tif[g])
    );
  end

  // ==========================================================
  // address decode
  always_comb
  begin
    hit_ctrl = '0;
    hit_cnt = '0;
    hit_per = '0;
    hit_flags = (paddr == OFS_FLAGS);
    for (int i = 0; i < NUM_TMR; i++)
    begin
      if (paddr == gpt_reg_addr(i, OFS_CTRL))
        hit_ctrl[i] = 1'b1;
      else if (paddr == gpt_reg_addr(i, OFS_COUNT))
        hit_cnt[i] = 1'b1;
      else if (paddr == gpt_reg_addr(i, OFS_PERIOD))
        hit_per[i] = 1'b1;
    end
  end

  // ==========================================================
  // next state: counting, events, bus reads and writes
  always_comb
  begin
    logic [32:0] st;
    logic [15:0] msk;
    logic [NUM_TMR-1:0] clr;
    st = '0;
    msk = MASK_SOLO;
    clr = '0;
    s_next = s_reg;
    ev = '0;
    // ready is held one cycle only, so every access has one wait
    acc = psel && penable;
    wr = acc && s_reg.pready && pwrite;
    s_next.pready = acc && !s_reg.pready;
    s_next.pin_prev = ext_count_pin;
    for (int i = 0; i < NUM_TMR; i++)
    begin
      // gate falling edge ends an accumulation; a joined even stays quiet
      if (!(in_wide[i] && (i == T_A_EVEN || i == T_B_EVEN)))
        ev[i] = gated[i] && run_ok[i] && fall[i];
      // separate 16-bit timers
      if (!in_wide[i] && ptick[i])
      begin
        st = gpt_step({16'h0000, s_reg.cnt[i]}, {16'h0000, s_reg.per[i]});
        s_next.cnt[i] = st[15:0];
        ev[i] = ev[i] || st[32];
      end
    end
    // joined pairs: even is the low word and supplies the count edge
    for (int p = T_A_EVEN; p <= T_B_EVEN; p += 2)
    begin
      if (in_wide[p] && ptick[p])
      begin
        st = gpt_step({s_reg.cnt[p + 1], s_reg.cnt[p]},
                      {s_reg.per[p + 1], s_reg.per[p]});
        {s_next.cnt[p + 1], s_next.cnt[p]} = st[31:0];
        ev[p + 1] = ev[p + 1] || st[32];
      end
    end
    // reads answer in the first access cycle, held while ready
    if (acc && !s_reg.pready)
    begin
      s_next.prdata = '0;
      for (int i = 0; i < NUM_TMR; i++)
      begin
        if (hit_ctrl[i])
          s_next.prdata[15:0] = s_reg.ctrl[i];
        else if (hit_cnt[i])
          s_next.prdata[15:0] = s_reg.cnt[i];
        else if (hit_per[i])
          s_next.prdata[15:0] = s_reg.per[i];
      end
      if (hit_flags)
        s_next.prdata[NUM_TMR-1:0] = s_reg.flag;
      s_next.pslverr = !(|{hit_ctrl, hit_cnt, hit_per, hit_flags});
    end
    else if (!acc)
      s_next.pslverr = 1'b0;
    // writes take effect at the edge where ready is seen high
    for (int i = 0; i < NUM_TMR; i++)
    begin
      msk = (i == T_SOLO) ? MASK_SOLO
          : ((i == T_A_EVEN || i == T_B_EVEN) ? MASK_EVEN : MASK_ODD);
      cnt_wr[i] = wr && hit_cnt[i]
                  && !(i == T_SOLO && solo_sync_run);
      if (wr && hit_ctrl[i])
        s_next.ctrl[i] = pwdata[15:0] & msk;
      if (cnt_wr[i])
        s_next.cnt[i] = pwdata[15:0];
      if (wr && hit_per[i])
        s_next.per[i] = pwdata[15:0];
    end
    if (wr && hit_flags)
      clr = pwdata[NUM_TMR-1:0];
    // a flag set in the same cycle as its clear stays set
    s_next.flag = (s_reg.flag & ~clr) | ev;
    s_next.dma = ev[T_B_ODD:T_A_EVEN];
    s_next.adc = ev[T_A_ODD];
    s_next.base = {s_next.cnt[T_A_ODD], s_next.cnt[T_A_EVEN]};
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.per <= {NUM_TMR{PERIOD_RST}};
    end
    else
      s_reg <= s_next;
  end

  // every output is a flop of the state word
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq_flag = s_reg.flag;
  assign adc1_trigger = s_reg.adc;
  assign dma_req = s_reg.dma;
  assign time_base_a_even = s_reg.base[0];
  assign time_base_a_odd = s_reg.base[1];

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_solo_off;
    (!s_reg.ctrl[T_SOLO][RUN_BIT] && !cnt_wr[T_SOLO])[*4];
  endsequence

  sequence s_solo_idle;
    (device_idle && s_reg.ctrl[T_SOLO][IDLE_BIT] && !cnt_wr[T_SOLO])[*4];
  endsequence

  property p_ctrl_reserved;
    (s_reg.ctrl[T_SOLO] & ~MASK_SOLO) == 16'h0000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("unimplemented control bits are set");

  property p_run_stop;
    s_solo_off |-> $stable(s_reg.cnt[T_SOLO]);
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("stopped timer still counts");

  property p_idle_halt;
    s_solo_idle |-> $stable(s_reg.cnt[T_SOLO]);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("timer counts in idle with idle-stop set");

  property p_period_wrap;
    (ptick[T_SOLO] && s_reg.cnt[T_SOLO] == s_reg.per[T_SOLO]
      && !cnt_wr[T_SOLO]) |=> (s_reg.cnt[T_SOLO] == 16'h0000)
      && s_reg.flag[T_SOLO];
  endproperty
  a_period_wrap: assert property (p_period_wrap)
    else $error("period match did not clear count and flag");

  property p_sync_write;
    (solo_sync_run && wr && hit_cnt[T_SOLO] && !ptick[T_SOLO])
      |=> $stable(s_reg.cnt[T_SOLO]);
  endproperty
  a_sync_write: assert property (p_sync_write)
    else $error("count write taken in synchronous counter mode");

  property p_wide_match;
    (wide_a && ptick[T_A_EVEN] && !(|cnt_wr)
      && {s_reg.cnt[T_A_ODD], s_reg.cnt[T_A_EVEN]}
      == {s_reg.per[T_A_ODD], s_reg.per[T_A_EVEN]})
      |=> s_reg.flag[T_A_ODD] && s_reg.cnt[T_A_ODD] == 16'h0000
      && s_reg.cnt[T_A_EVEN] == 16'h0000;
  endproperty
  a_wide_match: assert property (p_wide_match)
    else $error("32-bit match did not wrap and flag the odd timer");

  property p_wide_even_quiet;
    wide_a |-> !ev[T_A_EVEN];
  endproperty
  a_wide_even_quiet: assert property (p_wide_even_quiet)
    else $error("joined even timer raised its own event");

  property p_adc_source;
    s_reg.adc |-> s_reg.flag[T_A_ODD];
  endproperty
  a_adc_source: assert property (p_adc_source)
    else $error("converter trigger without first pair event");

  property p_dma_source;
    (s_reg.dma & ~s_reg.flag[T_B_ODD:T_A_EVEN]) == 4'h0;
  endproperty
  a_dma_source: assert property (p_dma_source)
    else $error("dma request without matching timer event");

  property p_gate_fall;
    (gated[T_SOLO] && run_ok[T_SOLO] && fall[T_SOLO])
      |=> s_reg.flag[T_SOLO];
  endproperty
  a_gate_fall: assert property (p_gate_fall)
    else $error("gate falling edge did not set the flag");

endmodule : gpt_timers

// [tb.sv]
/*
  tb: self-checking bench for the timer block, register traffic over
  APB and pin activity through the pin model.
  assumes: one pclk domain; expectations come from the control layout.
*/
`timescale 1ns/1ns
module tb;
  import gpt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [4:0] pins;
  logic device_idle = 1'b0;
  logic device_sleep = 1'b0;
  logic [4:0] irq_flag;
  logic adc1_trigger;
  logic [3:0] dma_req;
  logic [15:0] tb_even;
  logic [15:0] tb_odd;
  logic [31:0] rdat;
  logic err;
  logic adc_seen = 1'b0;
  logic [3:0] dma_seen = '0;
  logic seen_clr = 1'b0;
  int n_fail = 0;
  int checked = 0;
  int div;
  int exp_cnt;

  gpt_timers dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(pins), .device_idle(device_idle),
    .device_sleep(device_sleep), .irq_flag(irq_flag),
    .adc1_trigger(adc1_trigger), .dma_req(dma_req),
    .time_base_a_even(tb_even), .time_base_a_odd(tb_odd));
  gpt_pin_model pm_u (.pclk(pclk), .ext_count_pin(pins));

  // ============================================================
  // clock, and sticky capture of the one-cycle event pulses
  always #20 pclk = ~pclk;
  // one process owns the sticky bits, so a clear never races a capture
  always @(posedge pclk)
  begin
    if (seen_clr)
    begin
      adc_seen <= 1'b0;
      dma_seen <= '0;
    end
    else
    begin
      if (adc1_trigger === 1'b1) adc_seen <= 1'b1;
      dma_seen <= dma_seen | dma_req;
    end
  end

  // ============================================================
  // helpers
  function automatic logic [7:0] ra(input int i, input logic [7:0] f);
    return 8'(i * 12) + f;
  endfunction : ra
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one APB transfer; request held until pready, then one idle cycle
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [15:0] d);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      n_fail++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input int i, input logic [7:0] f, input logic [15:0] d);
    xfer(ra(i, f), 1'b1, d);
  endtask : wr
  task automatic rd(input int i, input logic [7:0] f);
    xfer(ra(i, f), 1'b0, 16'h0000);
  endtask : rd
  task automatic clr_seen;
    seen_clr <= 1'b1;
    @(posedge pclk);
    seen_clr <= 1'b0;
  endtask : clr_seen
  task automatic results;
    $display("checks=%0d mismatches=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // ============================================================
  // watchdog: the whole sequence needs well under 6000 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    results();
  end

  // ============================================================
  // test sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(0, OFS_CTRL); chk(rdat, 32'h0);
    rd(1, OFS_PERIOD); chk(rdat, 32'h0000FFFF);
    xfer(8'h40, 1'b0, 16'h0000); chk({31'h0, err}, 32'h1);
    chk(rdat, 32'h0);
    // unimplemented control bits read zero, per timer kind
    for (int i = 0; i < 5; i++)
    begin
      wr(i, OFS_CTRL, 16'hFFFF);
      rd(i, OFS_CTRL); chk(rdat[15:0], i == 0 ? MASK_SOLO : (i % 2 ? MASK_EVEN : MASK_ODD));
      wr(i, OFS_CTRL, 16'h0000);
    end
    // internal clock through every prescale code
    for (int k = 0; k < 4; k++)
    begin
      div = k == 0 ? 1 : (k == 1 ? 8 : (k == 2 ? 64 : 256));
      wr(0, OFS_COUNT, 16'h0000);
      wr(0, OFS_CTRL, 16'(16'h8000 | (k << 4)));
      repeat (4 * div) @(posedge pclk);
      wr(0, OFS_CTRL, 16'h0000);
      rd(0, OFS_COUNT);
      exp_cnt = (4 * div + 4) / div;
      chk({31'h0, rdat <= exp_cnt && rdat >= exp_cnt - 2}, 32'h1);
    end
    // period match wraps and flags; the standalone timer has no DMA
    wr(0, OFS_COUNT, 16'h0000);
    xfer(OFS_FLAGS, 1'b1, 16'h001F);
    clr_seen();
    wr(0, OFS_PERIOD, 16'h0003);
    wr(0, OFS_CTRL, 16'h8000);
    repeat (20) @(posedge pclk);
    wr(0, OFS_CTRL, 16'h0000);
    rd(0, OFS_COUNT); chk({31'h0, rdat <= 3}, 32'h1);
    xfer(OFS_FLAGS, 1'b0, 16'h0000); chk(rdat, 32'h1);
    chk({28'h0, dma_seen}, 32'h0);
    wr(0, OFS_PERIOD, 16'hFFFF);
    // gated timer: no count with gate low, flag on gate fall
    xfer(OFS_FLAGS, 1'b1, 16'h001F);
    wr(0, OFS_COUNT, 16'h0000);
    wr(0, OFS_CTRL, 16'h8040);
    repeat (10) @(posedge pclk);
    rd(0, OFS_COUNT); chk(rdat, 32'h0);
    pm_u.level(0, 1'b1);
    repeat (10) @(posedge pclk);
    pm_u.level(0, 1'b0);
    repeat (3) @(posedge pclk);
    xfer(OFS_FLAGS, 1'b0, 16'h0000); chk(rdat, 32'h1);
    wr(0, OFS_CTRL, 16'h0000);
    rd(0, OFS_COUNT); chk({31'h0, rdat >= 8 && rdat <= 12}, 32'h1);
    // asynchronous counter with the gate bit set: gate is ignored
    wr(0, OFS_COUNT, 16'h0000);
    wr(0, OFS_CTRL, 16'h8042);
    pm_u.pulse(0, 5);
    repeat (4) @(posedge pclk);
    wr(0, OFS_CTRL, 16'h0000);
    rd(0, OFS_COUNT); chk(rdat, 32'h5);
    // synchronous counter; count writes dropped while it runs
    wr(0, OFS_COUNT, 16'h0000);
    wr(0, OFS_CTRL, 16'h8006);
    pm_u.pulse(0, 4);
    repeat (6) @(posedge pclk);
    wr(0, OFS_COUNT, 16'h1234);
    rd(0, OFS_COUNT); chk(rdat, 32'h4);
    wr(0, OFS_CTRL, 16'h0000);
    wr(0, OFS_COUNT, 16'h0000);
    wr(0, OFS_CTRL, 16'h8016);
    pm_u.pulse(0, 16);
    repeat (6) @(posedge pclk);
    rd(0, OFS_COUNT); chk(rdat, 32'h2);
    wr(0, OFS_CTRL, 16'h0000);
    wr(0, OFS_COUNT, 16'h1234);
    rd(0, OFS_COUNT); chk(rdat, 32'h1234);
    // idle stop halts, idle continue keeps counting
    wr(0, OFS_COUNT, 16'h0000);
    device_idle <= 1'b1;
    wr(0, OFS_CTRL, 16'hA000);
    repeat (10) @(posedge pclk);
    rd(0, OFS_COUNT); chk(rdat, 32'h0);
    wr(0, OFS_CTRL, 16'h8000);
    repeat (10) @(posedge pclk);
    rd(0, OFS_COUNT); chk({31'h0, rdat > 0}, 32'h1);
    device_idle <= 1'b0;
    wr(0, OFS_CTRL, 16'h0000);
    // joined pair A: odd control ignored, event on the odd timer only
    xfer(OFS_FLAGS, 1'b1, 16'h001F);
    clr_seen();
    wr(2, OFS_CTRL, 16'h8030);
    wr(1, OFS_PERIOD, 16'h0002);
    wr(2, OFS_PERIOD, 16'h0000);
    wr(1, OFS_COUNT, 16'h0000);
    wr(2, OFS_COUNT, 16'h0000);
    wr(1, OFS_CTRL, 16'h8008);
    repeat (10) @(posedge pclk);
    wr(1, OFS_CTRL, 16'h0000);
    xfer(OFS_FLAGS, 1'b0, 16'h0000); chk(rdat, 32'h4);
    chk({27'h0, irq_flag}, 32'h4);
    chk({31'h0, adc_seen}, 32'h1);
    chk({28'h0, dma_seen}, 32'h2);
    // low word carries into the high word
    wr(2, OFS_CTRL, 16'h0000);
    wr(1, OFS_PERIOD, 16'hFFFF);
    wr(2, OFS_PERIOD, 16'hFFFF);
    wr(1, OFS_COUNT, 16'hFFFE);
    wr(2, OFS_COUNT, 16'h0000);
    wr(1, OFS_CTRL, 16'h8008);
    repeat (5) @(posedge pclk);
    wr(1, OFS_CTRL, 16'h0000);
    rd(2, OFS_COUNT); chk(rdat, 32'h1);
    chk({16'h0, tb_odd}, 32'h1);
    chk({16'h0, tb_even}, 32'h7);
    rd(1, OFS_COUNT); chk(rdat, 32'h7);
    // joined pair in idle: even idle-stop clear keeps it counting
    wr(2, OFS_CTRL, 16'h2000);
    wr(1, OFS_COUNT, 16'h0000);
    wr(2, OFS_COUNT, 16'h0000);
    device_idle <= 1'b1;
    wr(1, OFS_CTRL, 16'h8008);
    repeat (5) @(posedge pclk);
    wr(1, OFS_CTRL, 16'h0000);
    device_idle <= 1'b0;
    rd(1, OFS_COUNT); chk(rdat, 32'h9);
    wr(2, OFS_CTRL, 16'h0000);
    // pair B in sleep: external sync counting goes on, internal stops
    device_sleep <= 1'b1;
    wr(3, OFS_COUNT, 16'h0000);
    wr(3, OFS_CTRL, 16'h8002);
    pm_u.pulse(3, 3);
    repeat (6) @(posedge pclk);
    rd(3, OFS_COUNT); chk(rdat, 32'h3);
    wr(3, OFS_CTRL, 16'h0000);
    wr(4, OFS_COUNT, 16'h0000);
    wr(4, OFS_CTRL, 16'h8000);
    repeat (10) @(posedge pclk);
    rd(4, OFS_COUNT); chk(rdat, 32'h0);
    device_sleep <= 1'b0;
    wr(4, OFS_CTRL, 16'h0000);
    xfer(OFS_FLAGS, 1'b1, 16'h001F);
    xfer(OFS_FLAGS, 1'b0, 16'h0000); chk(rdat, 32'h0);
    results();
  end
endmodule : tb
